// ==== bench/clock_gen_ctrl_asserts.sv ====
// checker: port-level assertions for the clock generator register block
`timescale 1ns/100ps
module clock_gen_ctrl_asserts
  import clock_gen_pkg::*;
(
  input wire logic I_REF_CLK,
  input wire logic I_RST_N,
  input wire logic [ADDR_W-1:0] I_ADDR,
  input wire logic [DATA_W-1:0] I_WR_DATA,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic [DATA_W-1:0] O_RD_DATA,
  input wire logic I_WRITE_PROTECT_RELEASED,
  input wire logic I_INTERNAL_OSC_STABLE_EVT,
  input wire logic I_SLOW_OSC_STABLE_EVT,
  input wire logic I_FAST_OSC_STABLE_EVT,
  input wire logic I_AUTOTRIM_DONE_EVT,
  input wire logic I_SLOW_OSC_STOP_EVT,
  input wire logic O_IRQ,
  input wire logic O_CLOCK_OUTPUT_PIN,
  input wire logic O_CLOCK_OUTPUT_PIN_OE,
  input wire logic [FAST_OSC_TRIM_W-1:0] O_FAST_OSC_TRIM,
  input wire logic [INTERNAL_OSC_TRIM_W-1:0] O_INTERNAL_OSC_TRIM
);
  // ==========================================================================
  // helper terms
  logic evt_any;
  logic irq_reg_wr;
  // write to enable or clear this cycle
  assign irq_reg_wr = I_WR && (I_ADDR == IRQ_ENABLE_ADDR || I_ADDR == IRQ_CLEAR_ADDR);
  // any cause event this cycle
  assign evt_any = I_INTERNAL_OSC_STABLE_EVT | I_SLOW_OSC_STABLE_EVT | I_FAST_OSC_STABLE_EVT |
    I_AUTOTRIM_DONE_EVT | I_SLOW_OSC_STOP_EVT;
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RST_N);
  sequence trim_wr_s;
    I_WR && I_ADDR == OSCILLATOR_TRIM_ADDR && I_WRITE_PROTECT_RELEASED;
  endsequence
  sequence ctrl_wr_s;
    I_WR && I_ADDR == OUTPUT_CONTROL_ADDR;
  endsequence
  // ==========================================================================
  // assertions
  a_read_idle_zero: assert property (!$past(I_RD) |-> O_RD_DATA == '0)
    else $error("read data not zero outside read slot");
  a_pin_off_low: assert property (!O_CLOCK_OUTPUT_PIN_OE |-> !O_CLOCK_OUTPUT_PIN)
    else $error("pin active while output disabled");
  a_trim_guard: assert property ($changed({O_FAST_OSC_TRIM, O_INTERNAL_OSC_TRIM}) |->
    $past(I_WR && I_ADDR == OSCILLATOR_TRIM_ADDR && I_WRITE_PROTECT_RELEASED, 2))
    else $error("trim changed without permitted write");
  a_trim_lands: assert property (trim_wr_s ##1 !(I_WR && I_ADDR == OSCILLATOR_TRIM_ADDR) |=>
    {O_FAST_OSC_TRIM, O_INTERNAL_OSC_TRIM} == $past({I_WR_DATA[12:8], I_WR_DATA[5:0]}, 2))
    else $error("trim output differs from written value");
  a_irq_has_cause: assert property ($rose(O_IRQ) |->
    $past(evt_any || (I_WR && I_ADDR == IRQ_ENABLE_ADDR), 2))
    else $error("interrupt rose without event or enable write");
  a_irq_sticky: assert property (O_IRQ && !irq_reg_wr && !$past(irq_reg_wr) |=> O_IRQ)
    else $error("interrupt dropped without clear or enable write");
  a_clear_drops_irq: assert property (I_WR && I_ADDR == IRQ_CLEAR_ADDR && !evt_any &&
    (I_WR_DATA[5:0] & IRQ_IMPLEMENTED_MASK) == IRQ_IMPLEMENTED_MASK |-> ##2 !O_IRQ)
    else $error("interrupt still high after full clear");
  a_oe_follows: assert property (ctrl_wr_s ##1 !(I_WR && I_ADDR == OUTPUT_CONTROL_ADDR) |=>
    O_CLOCK_OUTPUT_PIN_OE == $past(I_WR_DATA[0], 2))
    else $error("output enable differs from control write");
  a_enable_starts_low: assert property ($rose(O_CLOCK_OUTPUT_PIN_OE) |-> !O_CLOCK_OUTPUT_PIN)
    else $error("pin high on the cycle the output was enabled");
endmodule // clock_gen_ctrl_asserts

bind clock_gen_ctrl clock_gen_ctrl_asserts clock_gen_ctrl_asserts_inst (
  .I_REF_CLK(I_REF_CLK), .I_RST_N(I_RST_N), .I_ADDR(I_ADDR), .I_WR_DATA(I_WR_DATA), .I_WR(I_WR),
  .I_RD(I_RD), .O_RD_DATA(O_RD_DATA), .I_WRITE_PROTECT_RELEASED(I_WRITE_PROTECT_RELEASED),
  .I_INTERNAL_OSC_STABLE_EVT(I_INTERNAL_OSC_STABLE_EVT), .I_SLOW_OSC_STABLE_EVT(I_SLOW_OSC_STABLE_EVT),
  .I_FAST_OSC_STABLE_EVT(I_FAST_OSC_STABLE_EVT), .I_AUTOTRIM_DONE_EVT(I_AUTOTRIM_DONE_EVT),
  .I_SLOW_OSC_STOP_EVT(I_SLOW_OSC_STOP_EVT), .O_IRQ(O_IRQ), .O_CLOCK_OUTPUT_PIN(O_CLOCK_OUTPUT_PIN),
  .O_CLOCK_OUTPUT_PIN_OE(O_CLOCK_OUTPUT_PIN_OE), .O_FAST_OSC_TRIM(O_FAST_OSC_TRIM),
  .O_INTERNAL_OSC_TRIM(O_INTERNAL_OSC_TRIM));

// ==== bench/clock_gen_ctrl_test.sv ====
// testbench: registers, interrupts, trim and clock output of clock_gen_ctrl
`timescale 1ns/100ps
module clock_gen_ctrl_test;
  import clock_gen_pkg::*;
  // ==========================================================================
  // stimulus and observation
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic wp = 1'b0;
  logic sleep = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] rv;
  logic [5:0] evt = '0;
  logic [3:0] src_clk = '0;
  logic irq;
  logic pin;
  logic oe;
  logic [4:0] ftrim;
  logic [5:0] itrim;
  int n_fail = 0;
  int checks_done = 0;
  int cyc = 0;
  int base[4] = '{8, 4, 6, 10};
  int slow_sh[8] = '{0, 1, 2, 3, 8, 10, 12, 15};
  int ib[5] = '{0, 1, 2, 4, 5};
  clock_gen_ctrl clock_gen_ctrl_inst (
    .I_REF_CLK(clk), .I_RST_N(rst_n), .I_ADDR(addr), .I_WR_DATA(wdata), .I_WR(wr), .I_RD(rd),
    .O_RD_DATA(rdata), .I_INTERNAL_OSC_CLOCK(src_clk[0]), .I_SLOW_OSC_CLOCK(src_clk[1]),
    .I_FAST_OSC_CLOCK(src_clk[2]), .I_SYSTEM_CLOCK(src_clk[3]), .I_SLEEP_OR_HALT(sleep),
    .I_WRITE_PROTECT_RELEASED(wp), .I_INTERNAL_OSC_STABLE_EVT(evt[0]), .I_SLOW_OSC_STABLE_EVT(evt[1]),
    .I_FAST_OSC_STABLE_EVT(evt[2]), .I_AUTOTRIM_DONE_EVT(evt[4]), .I_SLOW_OSC_STOP_EVT(evt[5]),
    .O_IRQ(irq), .O_CLOCK_OUTPUT_PIN(pin), .O_CLOCK_OUTPUT_PIN_OE(oe), .O_FAST_OSC_TRIM(ftrim),
    .O_INTERNAL_OSC_TRIM(itrim));
  // reference clock, 50 ns period
  initial forever #25 clk = ~clk;
  // source clocks: internal 8, slow 4, fast 6, system 10 reference periods
  initial begin
    #13;
    fork
      forever #200 src_clk[0] = ~src_clk[0];
      forever #100 src_clk[1] = ~src_clk[1];
      forever #150 src_clk[2] = ~src_clk[2];
      forever #250 src_clk[3] = ~src_clk[3];
    join
  end
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 100000) begin
      n_fail++;
      summarize();
    end
  end
  // ==========================================================================
  // shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    checks_done++;
    if (got !== want) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 rv = rdata;
  endtask
  task automatic pulse(input int b);
    @(posedge clk);
    evt[b] <= 1'b1;
    @(posedge clk);
    evt[b] <= 1'b0;
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_regs();
    chk({ftrim, itrim}, {FAST_OSC_TRIM_RESET, INTERNAL_OSC_TRIM_RESET});
    rd_reg(OSCILLATOR_TRIM_ADDR);
    chk(rv, {3'h0, FAST_OSC_TRIM_RESET, 2'h0, INTERNAL_OSC_TRIM_RESET});
    wr_reg(IRQ_ENABLE_ADDR, 16'hFFFF);
    rd_reg(IRQ_ENABLE_ADDR);
    chk(rv, 16'h0037);
    wr_reg(OUTPUT_CONTROL_ADDR, 16'hFFFE);
    rd_reg(OUTPUT_CONTROL_ADDR);
    chk(rv, 16'h007C);
    wr_reg(IRQ_STATUS_ADDR, 16'hFFFF);
    rd_reg(IRQ_STATUS_ADDR);
    chk(rv, 16'h0000);
    rd_reg(4'hF);
    chk(rv, 16'h0000);
    wr_reg(IRQ_ENABLE_ADDR, 16'h0000);
  endtask
  task automatic t_irq(input int b);
    logic [15:0] m;
    m = 16'h0001 << b;
    wr_reg(IRQ_ENABLE_ADDR, m);
    pulse(b);
    settle(2);
    chk(irq, 1'b1);
    wr_reg(IRQ_CLEAR_ADDR, ~m);
    rd_reg(IRQ_STATUS_ADDR);
    chk(rv, m);
    wr_reg(IRQ_CLEAR_ADDR, 16'h0037);
    settle(2);
    chk(irq, 1'b0);
    rd_reg(IRQ_STATUS_ADDR);
    chk(rv, 16'h0000);
    pulse(b);
    wr_reg(IRQ_ENABLE_ADDR, 16'h0000);
    settle(2);
    chk(irq, 1'b0);
    wr_reg(IRQ_CLEAR_ADDR, 16'h0037);
  endtask
  task automatic t_trim();
    wr_reg(OSCILLATOR_TRIM_ADDR, 16'hFFFF);
    rd_reg(OSCILLATOR_TRIM_ADDR);
    chk(rv, {3'h0, FAST_OSC_TRIM_RESET, 2'h0, INTERNAL_OSC_TRIM_RESET});
    @(posedge clk);
    wp <= 1'b1; // trim writes stand for software with the oscillators stopped
    wr_reg(OSCILLATOR_TRIM_ADDR, 16'hFFFF);
    rd_reg(OSCILLATOR_TRIM_ADDR);
    chk(rv, 16'h1F3F);
    wr_reg(OSCILLATOR_TRIM_ADDR, 16'h0000);
    settle(1);
    chk({ftrim, itrim}, 11'h000);
    @(posedge clk);
    wp <= 1'b0;
  endtask
  task automatic t_out(input logic [1:0] s, input logic [2:0] d);
    longint t0;
    int want;
    wr_reg(OUTPUT_CONTROL_ADDR, {9'h0, d, s, 2'b00});
    wr_reg(OUTPUT_CONTROL_ADDR, {9'h0, d, s, 2'b01});
    want = base[s] << ((s == 2'd1) ? slow_sh[d] : (s == 2'd3) ? 0 : int'(d));
    @(posedge pin);
    t0 = $time;
    @(posedge pin);
    chk(32'(($time - t0) / 50), want);
  endtask
  task automatic t_sleep();
    logic p;
    logic moved;
    moved = 1'b0;
    sleep <= 1'b1;
    settle(4);
    p = pin;
    repeat (20) begin
      settle(1);
      moved = moved | (pin !== p);
    end
    chk(moved, 1'b0);
    @(posedge clk);
    sleep <= 1'b0;
    wr_reg(OUTPUT_CONTROL_ADDR, 16'h0000);
    settle(2);
    chk({oe, pin}, 2'b00);
  endtask
  // ==========================================================================
  // verdict
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    foreach (ib[i]) t_irq(ib[i]);
    t_trim();
    for (int d = 0; d < 8; d++) begin
      t_out(2'd0, d[2:0]);
      t_out(2'd2, d[2:0]);
      if (d < 7) t_out(2'd1, d[2:0]);
    end
    t_out(2'd3, 3'd7);
    t_sleep();
    summarize();
  end
endmodule // clock_gen_ctrl_test

// ==== hdl/clock_gen_ctrl.sv ====
// module: clock generator interrupt enables, clock output channel and oscillator trim registers
//
// Contract
// - Enable bits 5 and 4 gate the slow oscillator stop and auto-trim done interrupts, 1 enabling.
// - Enable bits 2, 1 and 0 gate the fast, slow and internal oscillator stable interrupts.
// - Each cause flag is set by its event and cleared only by writing 1; writing 0 does nothing.
// - Source code 0 picks internal, 1 slow, 2 fast and 3 system clock, which is never divided.
// - Internal and fast sources divide by two to the power of the divide code, 1/1 up to 1/128.
// - The slow source divides by 1, 2, 4, 8, 256, 1024, 4096 and 32768 for codes 0 to 7.
// - With the system clock selected, the output stops while the device sleeps or halts.
// - The output enable bit drives the divided clock onto the pin when 1 and disables it when 0.
// - The output is not synchronised to enable writes, so a short pulse may appear on switching.
// - A five-bit fast oscillator trim field, larger codes giving a higher frequency.
// - A six-bit internal oscillator trim field, larger codes giving a higher frequency.
// - Trim fields load factory values at reset and are written only while protection is released.
//
// Decided for this implementation: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
module clock_gen_ctrl
  import clock_gen_pkg::*;
#(
  parameter logic [FAST_OSC_TRIM_W-1:0] FAST_TRIM_FACTORY = FAST_OSC_TRIM_RESET,
  parameter logic [INTERNAL_OSC_TRIM_W-1:0] INTERNAL_TRIM_FACTORY = INTERNAL_OSC_TRIM_RESET
) (
  input wire logic I_REF_CLK,
  input wire logic I_RST_N,
  input wire logic [ADDR_W-1:0] I_ADDR,
  input wire logic [DATA_W-1:0] I_WR_DATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [DATA_W-1:0] O_RD_DATA,
  input wire logic I_INTERNAL_OSC_CLOCK,
  input wire logic I_SLOW_OSC_CLOCK,
  input wire logic I_FAST_OSC_CLOCK,
  input wire logic I_SYSTEM_CLOCK,
  input wire logic I_SLEEP_OR_HALT,
  input wire logic I_WRITE_PROTECT_RELEASED,
  input wire logic I_INTERNAL_OSC_STABLE_EVT,
  input wire logic I_SLOW_OSC_STABLE_EVT,
  input wire logic I_FAST_OSC_STABLE_EVT,
  input wire logic I_AUTOTRIM_DONE_EVT,
  input wire logic I_SLOW_OSC_STOP_EVT,
  output logic O_IRQ,
  output logic O_CLOCK_OUTPUT_PIN,
  output logic O_CLOCK_OUTPUT_PIN_OE,
  output logic [FAST_OSC_TRIM_W-1:0] O_FAST_OSC_TRIM,
  output logic [INTERNAL_OSC_TRIM_W-1:0] O_INTERNAL_OSC_TRIM
);

  logic [IRQ_W-1:0] irq_enable;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_event;
  output_control_s output_control;
  trim_s oscillator_trim;
  logic wr_enable;
  logic wr_clear;
  logic wr_control;
  logic wr_trim;
  logic [NUM_SRC-1:0] src_raw;
  logic [NUM_SRC-1:0] src_meta;
  logic [NUM_SRC-1:0] src_sync;
  logic [NUM_SRC-1:0] src_prev;
  logic [NUM_SRC-1:0] src_tick;
  logic sleep_meta;
  logic sleep_sync;
  logic sel_tick;
  logic sel_level;
  logic sel_halted;
  logic [3:0] ratio_log2;
  logic [HALF_W-1:0] next_half;
  logic div_clk;
  logic [DATA_W-1:0] next_rd_data;

  // ==========================================================================
  // register write decode
  assign wr_enable = I_WR && (I_ADDR == IRQ_ENABLE_ADDR);
  assign wr_clear = I_WR && (I_ADDR == IRQ_CLEAR_ADDR);
  assign wr_control = I_WR && (I_ADDR == OUTPUT_CONTROL_ADDR);
  assign wr_trim = I_WR && (I_ADDR == OSCILLATOR_TRIM_ADDR) && I_WRITE_PROTECT_RELEASED;

  // interrupt enable register, implemented bits only
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      irq_enable <= IRQ_ENABLE_RESET;
    end else if (wr_enable) begin
      irq_enable <= I_WR_DATA[IRQ_W-1:0] & IRQ_IMPLEMENTED_MASK;
    end
  end

  // ==========================================================================
  // interrupt cause flags
  always_comb begin
    irq_event = '0;
    irq_event[INTERNAL_OSC_STABLE_BIT] = I_INTERNAL_OSC_STABLE_EVT;
    irq_event[SLOW_OSC_STABLE_BIT] = I_SLOW_OSC_STABLE_EVT;
    irq_event[FAST_OSC_STABLE_BIT] = I_FAST_OSC_STABLE_EVT;
    irq_event[AUTOTRIM_DONE_BIT] = I_AUTOTRIM_DONE_EVT;
    irq_event[SLOW_OSC_STOP_BIT] = I_SLOW_OSC_STOP_EVT;
  end

  // sticky flags: write 1 clears, a same-cycle event wins
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      irq_status <= '0;
    end else begin
      irq_status <= ((irq_status & ~({IRQ_W{wr_clear}} & I_WR_DATA[IRQ_W-1:0])) | irq_event)
        & IRQ_IMPLEMENTED_MASK;
    end
  end

  // interrupt request from flag and enable
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_IRQ <= 1'b0;
    end else begin
      O_IRQ <= |(irq_status & irq_enable);
    end
  end

  // ==========================================================================
  // clock output control register
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      output_control <= OUTPUT_CONTROL_RESET;
    end else if (wr_control) begin
      output_control.output_divide_sel <= I_WR_DATA[OUTPUT_DIVIDE_SEL_LSB +: 3];
      output_control.output_source_sel <= output_source_e'(I_WR_DATA[OUTPUT_SOURCE_SEL_LSB +: 2]);
      output_control.output_pin_enable <= I_WR_DATA[OUTPUT_PIN_ENABLE_BIT];
    end
  end

  // ==========================================================================
  // oscillator trim register, factory values at reset
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      oscillator_trim <= '{FAST_TRIM_FACTORY, INTERNAL_TRIM_FACTORY};
    end else if (wr_trim) begin
      oscillator_trim.fast_osc_trim <= I_WR_DATA[FAST_OSC_TRIM_LSB +: FAST_OSC_TRIM_W];
      oscillator_trim.internal_osc_trim <= I_WR_DATA[INTERNAL_OSC_TRIM_W-1:0];
    end
  end

  // trim values straight to the oscillators; software keeps them stopped meanwhile
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_FAST_OSC_TRIM <= FAST_TRIM_FACTORY;
      O_INTERNAL_OSC_TRIM <= INTERNAL_TRIM_FACTORY;
    end else begin
      O_FAST_OSC_TRIM <= oscillator_trim.fast_osc_trim;
      O_INTERNAL_OSC_TRIM <= oscillator_trim.internal_osc_trim;
    end
  end

  // ==========================================================================
  // source clocks sampled by two flops, third flop for edge detect
  assign src_raw = {I_SYSTEM_CLOCK, I_FAST_OSC_CLOCK, I_SLOW_OSC_CLOCK, I_INTERNAL_OSC_CLOCK};

  generate
    for (genvar g = 0; g < NUM_SRC; g++) begin : g_src
      always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
          src_meta[g] <= 1'b0;
          src_sync[g] <= 1'b0;
          src_prev[g] <= 1'b0;
        end else begin
          src_meta[g] <= src_raw[g];
          src_sync[g] <= src_meta[g];
          src_prev[g] <= src_sync[g];
        end
      end
      assign src_tick[g] = src_sync[g] & ~src_prev[g];
    end
  endgenerate

  // sleep or halt indication synchroniser
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      sleep_meta <= 1'b0;
      sleep_sync <= 1'b0;
    end else begin
      sleep_meta <= I_SLEEP_OR_HALT;
      sleep_sync <= sleep_meta;
    end
  end

  // ==========================================================================
  // source select and ratio decode
  always_comb begin
    sel_tick = src_tick[output_control.output_source_sel];
    sel_level = src_sync[output_control.output_source_sel];
    sel_halted = (output_control.output_source_sel == SRC_SYSTEM_CLOCK) && sleep_sync;
    ratio_log2 = {1'b0, output_control.output_divide_sel};
    unique case (output_control.output_source_sel)
      SRC_SLOW_OSC: ratio_log2 = slow_ratio_log2(output_control.output_divide_sel);
      SRC_SYSTEM_CLOCK: ratio_log2 = 4'h0;
      SRC_INTERNAL_OSC, SRC_FAST_OSC: ratio_log2 = {1'b0, output_control.output_divide_sel};
    endcase
    next_half = '0;
    if (ratio_log2 != 4'h0) begin
      next_half = HALF_W'(16'h0001 << (ratio_log2 - 4'h1));
    end
  end

  // divided output clock, ticks frozen while the system clock is stopped
  clock_out_divider #(
    .HW(HALF_W)
  ) u_divider (
    .i_clk(I_REF_CLK),
    .i_rst_n(I_RST_N),
    .i_run(output_control.output_pin_enable),
    .i_tick(sel_tick & ~sel_halted),
    .i_level(sel_halted ? div_clk : sel_level), // holds its own level, no ping-pong through the pin flop
    .i_half(next_half),
    .o_clk(div_clk)
  );

  // ==========================================================================
  // pin drive; enable not aligned to the divided clock, so a short pulse may result
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_CLOCK_OUTPUT_PIN <= 1'b0;
      O_CLOCK_OUTPUT_PIN_OE <= 1'b0;
    end else begin
      O_CLOCK_OUTPUT_PIN <= div_clk & output_control.output_pin_enable;
      O_CLOCK_OUTPUT_PIN_OE <= output_control.output_pin_enable;
    end
  end

  // ==========================================================================
  // read mux, reserved bits zero, unmapped addresses zero
  always_comb begin
    next_rd_data = '0;
    unique case (I_ADDR)
      IRQ_ENABLE_ADDR: next_rd_data[IRQ_W-1:0] = irq_enable;
      IRQ_STATUS_ADDR: next_rd_data[IRQ_W-1:0] = irq_status;
      OUTPUT_CONTROL_ADDR: begin
        next_rd_data[OUTPUT_DIVIDE_SEL_LSB +: 3] = output_control.output_divide_sel;
        next_rd_data[OUTPUT_SOURCE_SEL_LSB +: 2] = output_control.output_source_sel;
        next_rd_data[OUTPUT_PIN_ENABLE_BIT] = output_control.output_pin_enable;
      end
      OSCILLATOR_TRIM_ADDR: begin
        next_rd_data[FAST_OSC_TRIM_LSB +: FAST_OSC_TRIM_W] = oscillator_trim.fast_osc_trim;
        next_rd_data[INTERNAL_OSC_TRIM_W-1:0] = oscillator_trim.internal_osc_trim;
      end
      default: next_rd_data = '0;
    endcase
  end

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_RD_DATA <= '0;
    end else begin
      O_RD_DATA <= I_RD ? next_rd_data : '0;
    end
  end

endmodule // clock_gen_ctrl

// ==== hdl/clock_gen_pkg.sv ====
// package: register map, field layouts, reset values and helpers of the clock generator subset
package clock_gen_pkg;

  // ==========================================================================
  // register bus
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [ADDR_W-1:0] IRQ_ENABLE_ADDR = 4'h0;
  localparam logic [ADDR_W-1:0] IRQ_STATUS_ADDR = 4'h1;
  localparam logic [ADDR_W-1:0] IRQ_CLEAR_ADDR = 4'h2;
  localparam logic [ADDR_W-1:0] OUTPUT_CONTROL_ADDR = 4'h3;
  localparam logic [ADDR_W-1:0] OSCILLATOR_TRIM_ADDR = 4'h4;

  // ==========================================================================
  // interrupt cause bit positions, shared by enable, status and clear
  localparam int IRQ_W = 6;
  localparam int INTERNAL_OSC_STABLE_BIT = 0;
  localparam int SLOW_OSC_STABLE_BIT = 1;
  localparam int FAST_OSC_STABLE_BIT = 2;
  localparam int AUTOTRIM_DONE_BIT = 4;
  localparam int SLOW_OSC_STOP_BIT = 5;
  localparam logic [IRQ_W-1:0] IRQ_IMPLEMENTED_MASK = 6'h37;
  localparam logic [IRQ_W-1:0] IRQ_ENABLE_RESET = 6'h00;

  // ==========================================================================
  // clock output control fields
  localparam int OUTPUT_PIN_ENABLE_BIT = 0;
  localparam int OUTPUT_SOURCE_SEL_LSB = 2;
  localparam int OUTPUT_DIVIDE_SEL_LSB = 4;
  localparam logic [2:0] OUTPUT_DIVIDE_RESET = 3'h0;

  typedef enum logic [1:0] {
    SRC_INTERNAL_OSC = 2'b00,
    SRC_SLOW_OSC = 2'b01,
    SRC_FAST_OSC = 2'b10,
    SRC_SYSTEM_CLOCK = 2'b11
  } output_source_e;

  typedef struct packed {
    logic [2:0] output_divide_sel;
    output_source_e output_source_sel;
    logic output_pin_enable;
  } output_control_s;

  localparam output_control_s OUTPUT_CONTROL_RESET = '{OUTPUT_DIVIDE_RESET, SRC_INTERNAL_OSC, 1'b0};

  // ==========================================================================
  // trim fields
  localparam int FAST_OSC_TRIM_LSB = 8;
  localparam int FAST_OSC_TRIM_W = 5;
  localparam int INTERNAL_OSC_TRIM_W = 6;
  localparam logic [FAST_OSC_TRIM_W-1:0] FAST_OSC_TRIM_RESET = 5'h10;
  localparam logic [INTERNAL_OSC_TRIM_W-1:0] INTERNAL_OSC_TRIM_RESET = 6'h20;

  typedef struct packed {
    logic [FAST_OSC_TRIM_W-1:0] fast_osc_trim;
    logic [INTERNAL_OSC_TRIM_W-1:0] internal_osc_trim;
  } trim_s;

  // ==========================================================================
  // divider: half period in source edges, zero meaning pass-through
  localparam int HALF_W = 15;
  localparam int NUM_SRC = 4;

  // log2 of the slow oscillator ratio for each divide code
  function automatic logic [3:0] slow_ratio_log2(input logic [2:0] code);
    logic [3:0] r;
    r = 4'h0;
    unique case (code)
      3'h0: r = 4'h0;
      3'h1: r = 4'h1;
      3'h2: r = 4'h2;
      3'h3: r = 4'h3;
      3'h4: r = 4'h8;
      3'h5: r = 4'hA;
      3'h6: r = 4'hC;
      3'h7: r = 4'hF;
    endcase
    return r;
  endfunction

endpackage

// ==== hdl/clock_out_divider.sv ====
// module: divides a sampled source clock by a power of two, held cleared while disabled
`timescale 1ns/100ps
module clock_out_divider
  import clock_gen_pkg::*;
#(
  parameter int HW = HALF_W
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_run,
  input wire logic i_tick,
  input wire logic i_level,
  input wire logic [HW-1:0] i_half,
  output logic o_clk
);

  logic [HW-1:0] count;

  // ==========================================================================
  // edge counter, toggling output every half period
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count <= '0;
      o_clk <= 1'b0;
    end else if (!i_run) begin
      count <= '0;
      o_clk <= 1'b0;
    end else if (i_half == '0) begin
      count <= '0;
      o_clk <= i_level; // undivided: follow source
    end else if (i_tick) begin
      if (count == i_half - HW'(1)) begin
        count <= '0;
        o_clk <= ~o_clk;
      end else begin
        count <= count + HW'(1);
      end
    end
  end

endmodule // clock_out_divider
